// ==== logic/shs_pkg.sv ====
// shared constants and carrier types of the sensor host serial port
package shs_pkg;
   // ------------------------------------------------------------
   // two-wire slave address and strap
   // ------------------------------------------------------------
   localparam logic [5:0] ADDR_HI = 6'h29; // upper six bits of 0x52 / 0x53
   localparam logic [1:0] STRAP_DLY = 2'h3; // cycles until the strap sync is valid
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [6:0] GCALL_ADDR = 7'h00;
   // ------------------------------------------------------------
   // timing: fast-plus high time against the oversampling clock
   // ------------------------------------------------------------
   localparam int SYS_CLK_NS = 4;
   localparam int FMP_HIGH_NS = 260;
   localparam int FMP_HIGH_CYC = FMP_HIGH_NS / SYS_CLK_NS; // shortest time, rounded down
   localparam int SYNC_LAT_CYC = 3;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_RX = 3'h2,
      ST_ACK = 3'h3,
      ST_TX = 3'h4,
      ST_TXACK = 3'h5
   } shs_i2c_st_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } shs_reg_req_t;
endpackage

// ==== logic/shs_spi_link.sv ====
// four-wire shift logic running on the serial clock
`timescale 1ns/10ps
module shs_spi_link (
   input wire logic sclk,
   input wire logic select_n,
   input wire logic mosi,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte,
   output logic rx_first,
   output logic rx_toggle
);
   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] cnt;
      logic first;
      logic [7:0] rx;
      logic rx_first;
      logic tog;
   } shs_link_st_t;

   shs_link_st_t s, n;
   logic [7:0] txs_q;
   logic miso_q;

   // ------------------------------------------------------------
   // receive: rising edge, msb first
   // ------------------------------------------------------------
   always_comb begin
      n = s;
      n.sh = {s.sh[6:0], mosi};
      n.cnt = s.cnt + 3'h1;
      if (s.cnt == 3'h7) begin
         n.rx = {s.sh[6:0], mosi};
         n.rx_first = s.first;
         n.first = 1'b0;
         n.tog = ~s.tog;
      end
   end

   // frame end clears the link side; the clock stops between frames
   always_ff @(posedge sclk or posedge select_n) begin
      if (select_n) begin
         s <= '{sh: 8'h00, cnt: 3'h0, first: 1'b1, rx: 8'h00, rx_first: 1'b0, tog: 1'b0};
      end else begin
         s <= n;
      end
   end

   // transmit: falling edge, so data is stable for the next rise
   always_ff @(negedge sclk or posedge select_n) begin
      if (select_n) begin
         txs_q <= 8'h00;
         miso_q <= 1'b0;
      end else if (s.cnt == 3'h0) begin
         txs_q <= {tx_byte[6:0], 1'b0};
         miso_q <= tx_byte[7];
      end else begin
         txs_q <= {txs_q[6:0], 1'b0};
         miso_q <= txs_q[7];
      end
   end

   assign miso = miso_q;
   assign rx_byte = s.rx;
   assign rx_first = s.rx_first;
   assign rx_toggle = s.tog;
endmodule // shs_spi_link

// ==== logic/shs_host_port.sv ====
// host serial port: two-wire slave, four-wire select and shared register pointer
`timescale 1ns/10ps
module shs_host_port (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic SPI_SCLK,
   input wire logic SPI_SELECT_N,
   input wire logic ADDR_SEL_MISO_IN,
   output logic MISO_OUT,
   output logic MISO_OE,
   output shs_pkg::shs_reg_req_t REG_REQ,
   input wire logic [7:0] REG_RDATA,
   output logic SPI_MODE
);
   // sync must settle well inside the shortest scl high time
   if (shs_pkg::SYNC_LAT_CYC >= shs_pkg::FMP_HIGH_CYC) begin : g_chk
      $error("system clock too slow for fast-plus oversampling");
   end

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [1:0] sel_s;
      logic [1:0] adr_s;
      logic [3:0] tog_s;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic addr_lsb;
      logic spi_mode;
      shs_pkg::shs_i2c_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic ptr_pend;
      logic [7:0] ptr;
      logic sda_oe;
      logic spi_rd;
      logic rd_load;
      logic [7:0] tx_byte;
      logic miso_oe;
      shs_pkg::shs_reg_req_t req;
   } shs_port_st_t;

   shs_port_st_t s, n;
   logic scl, sda, rise, fall, start, stop, spi_ev, addr_hit;
   logic link_miso, link_first, link_tog;
   logic [7:0] link_rx;

   // ------------------------------------------------------------
   // four-wire link domain
   // ------------------------------------------------------------
   shs_spi_link u_link (
      .sclk(SPI_SCLK),
      .select_n(SPI_SELECT_N),
      .mosi(SDA_IN),
      .tx_byte(s.tx_byte),
      .miso(link_miso),
      .rx_byte(link_rx),
      .rx_first(link_first),
      .rx_toggle(link_tog)
   );

   // ------------------------------------------------------------
   // pin conditions, from the second sync stage onward
   // ------------------------------------------------------------
   assign scl = s.scl_s[1];
   assign sda = s.sda_s[1];
   assign rise = scl & ~s.scl_s[2];
   assign fall = ~scl & s.scl_s[2];
   assign start = scl & s.scl_s[2] & s.sda_s[2] & ~sda;
   assign stop = scl & s.scl_s[2] & ~s.sda_s[2] & sda;
   assign addr_hit = (s.sh[7:1] == {shs_pkg::ADDR_HI, s.addr_lsb});
   // toggle runs one stage deeper than select, so a frame-end reset
   // of the link toggle is masked before it can look like a byte
   assign spi_ev = (s.tog_s[2] != s.tog_s[3]) & ~s.sel_s[1] & s.spi_mode;

   // next state
   always_comb begin
      n = s;
      n.req.we = 1'b0;
      n.req.re = 1'b0;
      n.scl_s = {s.scl_s[1:0], SCL_IN};
      n.sda_s = {s.sda_s[1:0], SDA_IN};
      n.sel_s = {s.sel_s[0], SPI_SELECT_N};
      n.adr_s = {s.adr_s[0], ADDR_SEL_MISO_IN};
      n.tog_s = {s.tog_s[2:0], link_tog};
      // strap caught once, after its sync has filled
      if (!s.strap_done) begin
         n.strap_cnt = s.strap_cnt + 2'h1;
         if (s.strap_cnt == shs_pkg::STRAP_DLY) begin
            n.addr_lsb = s.adr_s[1];
            n.strap_done = 1'b1;
         end
      end
      // only power-on reset leaves four-wire mode
      if (!s.sel_s[1]) begin
         n.spi_mode = 1'b1;
      end
      n.miso_oe = n.spi_mode & ~s.sel_s[1];
      // two-wire slave; scl is never driven, so no stretching
      if (s.spi_mode || !s.strap_done) begin
         n.st = shs_pkg::ST_IDLE;
         n.sda_oe = 1'b0;
      end else if (start) begin
         n.st = shs_pkg::ST_ADDR; // repeated start keeps the pointer
         n.cnt = 4'h0;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.st = shs_pkg::ST_IDLE;
         n.sda_oe = 1'b0;
      end else begin
         unique case (s.st)
            shs_pkg::ST_IDLE: begin
            end
            shs_pkg::ST_ADDR, shs_pkg::ST_RX: begin
               if (rise) begin
                  n.sh = {s.sh[6:0], sda};
                  n.cnt = s.cnt + 4'h1;
               end else if (fall && s.cnt == shs_pkg::BITS_PER_BYTE) begin
                  n.cnt = 4'h0;
                  if (s.st == shs_pkg::ST_RX) begin
                     n.st = shs_pkg::ST_ACK;
                     n.sda_oe = 1'b1;
                     if (s.ptr_pend) begin
                        n.ptr = s.sh;
                        n.ptr_pend = 1'b0;
                     end else begin
                        n.req.we = 1'b1;
                        n.req.addr = s.ptr;
                        n.req.wdata = s.sh;
                        n.ptr = s.ptr + 8'h01;
                     end
                  end else if (addr_hit) begin
                     n.st = shs_pkg::ST_ACK;
                     n.sda_oe = 1'b1;
                     n.rw = s.sh[0];
                     n.ptr_pend = ~s.sh[0];
                     n.req.re = s.sh[0];
                     n.req.addr = s.ptr;
                  end else begin
                     n.st = shs_pkg::ST_IDLE;
                  end
               end
            end
            shs_pkg::ST_ACK: begin
               if (fall) begin
                  if (s.rw) begin
                     n.st = shs_pkg::ST_TX;
                     n.sh = REG_RDATA;
                     n.sda_oe = ~REG_RDATA[7];
                     n.ptr = s.ptr + 8'h01;
                  end else begin
                     n.st = shs_pkg::ST_RX;
                     n.sda_oe = 1'b0;
                  end
               end
            end
            shs_pkg::ST_TX: begin
               if (rise) begin
                  n.cnt = s.cnt + 4'h1;
               end else if (fall) begin
                  if (s.cnt == shs_pkg::BITS_PER_BYTE) begin
                     n.st = shs_pkg::ST_TXACK;
                     n.sda_oe = 1'b0;
                  end else begin
                     n.sh = {s.sh[6:0], 1'b0};
                     n.sda_oe = ~s.sh[6];
                  end
               end
            end
            shs_pkg::ST_TXACK: begin
               // cnt stays 8 until the master ack is seen
               if (rise && s.cnt == shs_pkg::BITS_PER_BYTE) begin
                  if (sda) begin
                     n.st = shs_pkg::ST_IDLE; // nack ends the read
                  end else begin
                     n.cnt = 4'h0;
                     n.req.re = 1'b1;
                     n.req.addr = s.ptr;
                  end
               end else if (fall && s.cnt == 4'h0) begin
                  n.st = shs_pkg::ST_TX;
                  n.sh = REG_RDATA;
                  n.sda_oe = ~REG_RDATA[7];
                  n.ptr = s.ptr + 8'h01;
               end
            end
            default: begin
               n.st = shs_pkg::ST_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end
      // four-wire bytes: header is read flag plus 7-bit address
      if (s.rd_load) begin
         n.tx_byte = REG_RDATA;
         n.rd_load = 1'b0;
      end
      if (spi_ev) begin
         if (link_first) begin
            n.spi_rd = link_rx[7];
            n.ptr = {1'b0, link_rx[6:0]};
         end
         if (link_first ? link_rx[7] : s.spi_rd) begin
            n.req.re = 1'b1;
            n.req.addr = link_first ? {1'b0, link_rx[6:0]} : s.ptr;
            n.rd_load = 1'b1;
            n.ptr = (link_first ? {1'b0, link_rx[6:0]} : s.ptr) + 8'h01;
         end else if (!link_first) begin
            n.req.we = 1'b1;
            n.req.addr = s.ptr;
            n.req.wdata = link_rx;
            n.ptr = s.ptr + 8'h01;
         end
      end
   end

   // state register
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         s <= '{scl_s: 3'h7, sda_s: 3'h7, sel_s: 2'h3, adr_s: 2'h0, tog_s: 4'h0,
                strap_cnt: 2'h0, strap_done: 1'b0, addr_lsb: 1'b0, spi_mode: 1'b0,
                st: shs_pkg::ST_IDLE, cnt: 4'h0, sh: 8'h00, rw: 1'b0, ptr_pend: 1'b0,
                ptr: shs_pkg::PTR_RST, sda_oe: 1'b0, spi_rd: 1'b0, rd_load: 1'b0,
                tx_byte: 8'h00, miso_oe: 1'b0, req: '0};
      end else begin
         s <= n;
      end
   end

   assign SDA_OUT = 1'b0; // open drain: only the enable moves
   assign SDA_OE = s.sda_oe;
   assign MISO_OUT = link_miso;
   assign MISO_OE = s.miso_oe;
   assign REG_REQ = s.req;
   assign SPI_MODE = s.spi_mode;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   a_mode_sticky: assert property (s.spi_mode |=> s.spi_mode)
      else $error("four-wire mode was left without reset");
   a_spi_quiet: assert property (s.spi_mode |=> !SDA_OE)
      else $error("two-wire driver active in four-wire mode");
   a_start_release: assert property (start && !s.spi_mode && s.strap_done
      |=> !SDA_OE && s.st == shs_pkg::ST_ADDR)
      else $error("start did not restart address phase");
   a_addr_ack: assert property (s.st == shs_pkg::ST_ADDR && fall && !start && !stop
      && s.cnt == 4'h8 && addr_hit && !s.spi_mode |=> SDA_OE ##0 s.st == shs_pkg::ST_ACK)
      else $error("own address not acknowledged");
   a_no_gcall: assert property (s.st == shs_pkg::ST_ADDR && fall && !start && !stop
      && s.cnt == 4'h8 && s.sh[7:1] == shs_pkg::GCALL_ADDR |=> !SDA_OE)
      else $error("general call acknowledged");
   a_strap_hold: assert property (s.strap_done |=> $stable(s.addr_lsb))
      else $error("address strap changed after power-up");
   a_ptr_step: assert property (REG_REQ.we |-> s.ptr == REG_REQ.addr + 8'h01)
      else $error("pointer did not advance after a write");
   a_ptr_first: assert property (REG_REQ.we && !s.spi_mode |-> !s.ptr_pend)
      else $error("data written before register address");
   a_re_pulse: assert property (REG_REQ.re |=> !REG_REQ.re)
      else $error("read strobe longer than one cycle");
   a_miso_gate: assert property (MISO_OE |-> SPI_MODE && !$past(s.sel_s[1]))
      else $error("miso driven outside a four-wire frame");

   c_addr_ack: cover property (s.st == shs_pkg::ST_ADDR ##1 s.st == shs_pkg::ST_ACK);
   c_i2c_write: cover property (REG_REQ.we && !s.spi_mode);
   c_i2c_read: cover property (s.st == shs_pkg::ST_TXACK ##[1:300] s.st == shs_pkg::ST_TX);
   c_spi_byte: cover property (spi_ev && !link_first);
endmodule // shs_host_port

// ==== sim/shs_host_model.sv ====
// host-side bus master model: two-wire and four-wire master on shared wires
`timescale 1ns/10ps
module shs_host_model (
   input wire logic clk,
   input wire logic sda_in,
   input wire logic miso_in,
   output logic scl,
   output logic sda_drv,
   output logic select_n
);
   localparam int QTR = 63; // quarter bit in cycles, just under 1 Mbit/s
   // --------------------------------------------------------------
   // idle bus: lines released, clock high, not selected
   // --------------------------------------------------------------
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      select_n = 1'b1;
   end
   task automatic tick();
      repeat (QTR) @(posedge clk);
      #1;
   endtask
   // data falls while clock high; also used as repeated start
   task automatic start();
      sda_drv = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_drv = 1'b0;
      tick();
      scl = 1'b0;
      tick();
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_drv = 1'b1;
      tick();
   endtask
   // eight bits msb first plus acknowledge slot
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_drv = tx[i];
         tick();
         scl = 1'b1;
         tick();
         rx[i] = sda_in;
         tick();
         scl = 1'b0;
         tick();
      end
   endtask
   // clock stands low outside frames; released data shows its inverse
   task automatic spi_sel(input logic lvl);
      scl = 1'b0;
      #100;
      select_n = lvl;
      #100;
      if (lvl) begin
         sda_drv = ~sda_drv;
      end
   endtask
   // data set at the fall, read data taken at the rise
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sda_drv = tx[i];
         #62.5;
         scl = 1'b1;
         rx[i] = miso_in;
         #62.5;
         scl = 1'b0;
      end
   endtask
endmodule // shs_host_model

// ==== sim/sensor_host_serial_port_tb.sv ====
// self-checking bench of the host serial port against a queue-based register map
`timescale 1ns/10ps
module sensor_host_serial_port_tb;
   logic SYS_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic strap = 1'b0;
   logic [7:0] REG_RDATA = 8'h00;
   logic SDA_OUT, SDA_OE, MISO_OUT, MISO_OE, SPI_MODE;
   logic scl, sda_drv, select_n;
   logic [7:0] mem [256];
   logic [15:0] wq [$];
   logic [8:0] r;
   logic [7:0] rb, p, dv [3];
   logic [7:0] own;
   shs_pkg::shs_reg_req_t REG_REQ;
   int fail_count = 0;
   int tests_run = 0;
   // open-drain data wire with pull-up; shared strap and read-data pin
   wire sda_w = sda_drv & ~(SDA_OE & ~SDA_OUT);
   wire miso_w = MISO_OE ? MISO_OUT : strap;
   initial begin
      forever #2 SYS_CLK = ~SYS_CLK;
   end
   shs_host_port shs_host_port_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SCL_IN(scl),
      .SDA_IN(sda_w), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SPI_SCLK(scl),
      .SPI_SELECT_N(select_n), .ADDR_SEL_MISO_IN(miso_w), .MISO_OUT(MISO_OUT),
      .MISO_OE(MISO_OE), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .SPI_MODE(SPI_MODE));
   shs_host_model shs_host_model_i (.clk(SYS_CLK), .sda_in(sda_w), .miso_in(miso_w),
      .scl(scl), .sda_drv(sda_drv), .select_n(select_n));
   // register map model: writes logged; read data follows re in the same cycle,
   // since the four-wire path takes it at the edge that ends the re pulse
   always @(posedge SYS_CLK) begin
      #1;
      if (REG_REQ.we === 1'b1) begin
         mem[REG_REQ.addr] = REG_REQ.wdata;
         wq.push_back({REG_REQ.addr, REG_REQ.wdata});
      end
      if (REG_REQ.re === 1'b1) begin
         REG_RDATA = mem[REG_REQ.addr];
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // bounded wait for the logged writes
   task automatic wait_wq(input int n);
      for (int k = 0; k < 400 && wq.size() < n; k++) @(posedge SYS_CLK);
      if (wq.size() < n) begin
         fail_count++;
         close_out();
      end
   endtask
   task automatic do_reset(input logic s);
      strap = s;
      SYS_RST = 1'b1;
      repeat (10) @(posedge SYS_CLK);
      #1 SYS_RST = 1'b0;
      repeat (20) @(posedge SYS_CLK);
      #1 check("mode after reset", 16'(SPI_MODE), 16'h0000);
      check("drivers after reset", 16'({SDA_OE, MISO_OE}), 16'h0000);
   endtask
   initial begin
      #380us fail_count++;
      close_out();
   end
   // --------------------------------------------------------------
   // main sequence: both straps over two-wire, then four-wire latch
   // --------------------------------------------------------------
   initial begin
      void'($urandom(5));
      foreach (mem[i]) mem[i] = 8'($urandom);
      for (int s = 0; s < 2; s++) begin
         do_reset(s[0]);
         own = 8'hA4 | 8'(s << 1);
         // write crossing the pointer wrap
         p = 8'hFF;
         shs_host_model_i.start();
         shs_host_model_i.xfer({own, 1'b1}, r);
         check("address ack", 16'(r[0]), 16'h0000);
         shs_host_model_i.xfer({p, 1'b1}, r);
         check("pointer ack", 16'(r[0]), 16'h0000);
         for (int i = 0; i < 3; i++) begin
            dv[i] = 8'($urandom);
            shs_host_model_i.xfer({dv[i], 1'b1}, r);
            check("data ack", 16'(r[0]), 16'h0000);
         end
         shs_host_model_i.stop();
         wait_wq(3);
         for (int i = 0; i < 3; i++) begin
            check("write", wq.pop_front(), {p + 8'(i), dv[i]});
         end
         // read with repeated start, last byte not acknowledged
         shs_host_model_i.start();
         shs_host_model_i.xfer({own, 1'b1}, r);
         shs_host_model_i.xfer({8'h10, 1'b1}, r);
         shs_host_model_i.start();
         shs_host_model_i.xfer({own | 8'h01, 1'b1}, r);
         check("read address ack", 16'(r[0]), 16'h0000);
         for (int i = 0; i < 3; i++) begin
            shs_host_model_i.xfer({8'hFF, i == 2}, r);
            check("read", 16'(r[8:1]), 16'(mem[8'h10 + 8'(i)]));
         end
         shs_host_model_i.stop();
         // other strap address, general call, ten-bit header: all ignored
         foreach (dv[i]) dv[i] = (i == 0) ? (own ^ 8'h02) : ((i == 1) ? 8'h00 : 8'hF0);
         for (int i = 0; i < 3; i++) begin
            shs_host_model_i.start();
            shs_host_model_i.xfer({dv[i], 1'b1}, r);
            check("foreign ack", 16'(r[0]), 16'h0001);
            shs_host_model_i.stop();
         end
         check("no writes", 16'(wq.size()), 16'h0000);
      end
      // four-wire write then read of the same registers
      foreach (dv[i]) dv[i] = 8'($urandom);
      shs_host_model_i.spi_sel(1'b0);
      shs_host_model_i.spi_byte(8'h05, rb);
      shs_host_model_i.spi_byte(dv[0], rb);
      shs_host_model_i.spi_byte(dv[1], rb);
      shs_host_model_i.spi_sel(1'b1);
      wait_wq(2);
      check("mode latched", 16'(SPI_MODE), 16'h0001);
      check("spi write", wq.pop_front(), {8'h05, dv[0]});
      check("spi write", wq.pop_front(), {8'h06, dv[1]});
      shs_host_model_i.spi_sel(1'b0);
      shs_host_model_i.spi_byte(8'h85, rb);
      shs_host_model_i.spi_byte(8'hFF, rb);
      check("spi read", 16'(rb), 16'(dv[0]));
      shs_host_model_i.spi_byte(8'hFF, rb);
      check("spi read", 16'(rb), 16'(dv[1]));
      shs_host_model_i.spi_sel(1'b1);
      // two-wire traffic refused once four-wire is latched
      shs_host_model_i.start();
      shs_host_model_i.xfer({8'hA6, 1'b1}, r);
      check("latched ack", 16'(r[0]), 16'h0001);
      shs_host_model_i.stop();
      check("mode held", 16'(SPI_MODE), 16'h0001);
      do_reset(1'b0);
      close_out();
   end
endmodule // sensor_host_serial_port_tb
